// >>> tb_top.sv
// Self-checking bench of the TDM serial port against the framer model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  import tps_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic run = 1'b0;
  logic gci = 1'b0;
  logic ode_pin = 1'b0;
  logic ode_bit = 1'b0;
  logic cancel_valid = 1'b0;
  tps_cancel_t cancel = '0;
  logic sclk, fs, rin, sin, rout, rout_oe, sout, sout_oe, sample_valid, gci_mode, locked;
  logic [8:0] k;
  logic [7:0] frame, fr;
  tps_sample_t sample;
  int n_fail = 0;
  int tests_run = 0;

  always #5 clock_i = ~clock_i;

  tps_tdm_model tps_tdm_model_i (.run_i(run), .gci_i(gci), .sclk_o(sclk), .fs_o(fs), .rin_o(rin),
    .sin_o(sin), .k_o(k), .frame_o(frame));
  tps_serial_port tps_serial_port_i (.clock_i(clock_i), .rst_i(rst_i), .serial_bit_clock_i(sclk),
    .frame_sync_in_i(fs), .rin_i(rin), .sin_i(sin), .output_drive_enable_i(ode_pin),
    .output_drive_enable_bit_i(ode_bit), .cancel_valid_i(cancel_valid), .cancel_i(cancel),
    .rout_o(rout), .rout_oe_o(rout_oe), .sout_o(sout), .sout_oe_o(sout_oe),
    .sample_valid_o(sample_valid), .sample_o(sample), .gci_mode_o(gci_mode), .frame_locked_o(locked));

  function automatic logic bitof(input logic [7:0] b, input logic [8:0] c);
    return b[3'h7 - c[3:1]];
  endfunction

  // Each sample pair must match the slot just closed; slot 31 may land after the wrap.
  always @(posedge clock_i) begin
    fr = (sample.chan == 5'h1F && k < 9'h100) ? frame - 8'h01 : frame;
    if (sample_valid === 1'b1 && run && fr != 8'hFF && !(frame == 8'h00 && k == 9'h000)) begin
      `CHK(sample.rin, tps_tdm_model_i.pat(fr, sample.chan))
      `CHK(sample.sin, ~tps_tdm_model_i.pat(fr, sample.chan))
    end
  end

  // At each fall the bit launched one fall earlier has settled.
  always @(negedge sclk) begin
    if (run && frame != 8'hFF) begin
      `CHK(sout, bitof({3'h0, k[8:4]} ^ 8'h5A, k))
      if (frame != 8'h00) `CHK(rout, bitof(tps_tdm_model_i.pat(frame - 8'h01, k[8:4]), k))
    end
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Outputs other than sout and the sample bus must sit at their idle values while reset holds.
  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    #1;
    `CHK({rout, rout_oe, sout_oe, sample_valid, gci_mode, locked}, 6'h20)
    @(posedge clock_i);
    rst_i <= 1'b0;
  endtask

  // Back-to-back core returns fill every send slot.
  task automatic load_cancel;
    for (int n = 0; n < CHANNELS; n++) begin
      @(posedge clock_i);
      cancel_valid <= 1'b1;
      cancel <= '{chan: n[4:0], data: n[7:0] ^ 8'h5A};
    end
    @(posedge clock_i);
    cancel_valid <= 1'b0;
  endtask

  // Three frames in one pulse format, then detection and lock are judged.
  task automatic run_format(input logic g);
    int t;
    gci <= g;
    run <= 1'b0;
    do_reset();
    load_cancel();
    run <= 1'b1;
    t = 0;
    while (frame != 8'h03 && t < 20000) begin
      @(posedge clock_i);
      t++;
    end
    if (t == 20000) begin
      n_fail++;
      close_out();
    end
    `CHK({gci_mode, locked}, {g, 1'b1})
  endtask

  // Both enables follow the AND of the pin and the bit, pin through its synchroniser.
  task automatic check_drive;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i);
      {ode_pin, ode_bit} <= i[1:0];
      repeat (5) @(posedge clock_i);
      #1;
      `CHK({rout_oe, sout_oe}, {2{i == 3}})
    end
  endtask

  // Main sequence: low-active pulses, drive enable, then the other format.
  initial begin
    run_format(1'b0);
    check_drive();
    run_format(1'b1);
    close_out();
  end
endmodule
`default_nettype wire

// >>> tps_pkg.sv
// Shared constants and types of the TDM PCM serial port.
package tps_pkg;
  localparam int CHANNELS = 32;
  localparam int BITS_PER_CHAN = 8;
  localparam int CYC_PER_BIT = 2;
  localparam int CYC_PER_FRAME = CHANNELS * BITS_PER_CHAN * CYC_PER_BIT;
  localparam int CYC_W = $clog2(CYC_PER_FRAME);
  localparam int CHAN_W = $clog2(CHANNELS);
  localparam int BIT_W = $clog2(BITS_PER_CHAN);
  // Serial clock cycles a frame pulse line must hold one level before it counts as idle.
  localparam logic [3:0] IDLE_RUN = 4'h8;
  localparam logic [BIT_W-1:0] LAST_BIT = 3'h7;
  localparam int LOST_W = CYC_W + 1;
  localparam logic [LOST_W-1:0] LOST_LIMIT = 10'h201;
  localparam int SYNC_W = 5;

  // One channel sample pair handed to the echo canceller core.
  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [BITS_PER_CHAN-1:0] rin;
    logic [BITS_PER_CHAN-1:0] sin;
  } tps_sample_t;

  // One cancelled send sample returned by the core.
  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [BITS_PER_CHAN-1:0] data;
  } tps_cancel_t;
endpackage

// >>> tps_serial_port.sv
// Four-stream TDM PCM serial port with automatic frame pulse format detection.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Both serial outputs drive only when drive pin and drive bit are high.
// - Send output carries cancelled send samples, 32 timeslots per frame.
// - Receive output carries receive samples, 32 timeslots per frame.
// - Send input stream of 32 timeslots is accepted by the port.
// - Receive input stream of 32 timeslots is accepted by the port.
// - Frame pulse polarity is found automatically and aligns the frame counter.
// - The 4.096 MHz serial clock times shifting on all four streams.
// - All serial pins are synchronised into the master clock domain.
module tps_serial_port (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic serial_bit_clock_i,
  input wire logic frame_sync_in_i,
  input wire logic rin_i,
  input wire logic sin_i,
  input wire logic output_drive_enable_i,
  input wire logic output_drive_enable_bit_i,
  input wire logic cancel_valid_i,
  input wire tps_pkg::tps_cancel_t cancel_i,
  output logic rout_o,
  output logic rout_oe_o,
  output logic sout_o,
  output logic sout_oe_o,
  output logic sample_valid_o,
  output tps_pkg::tps_sample_t sample_o,
  output logic gci_mode_o,
  output logic frame_locked_o
);
  import tps_pkg::*;

  logic [SYNC_W-1:0] sync_q;
  logic sclk_s;
  logic fs_s;
  logic rin_s;
  logic sin_s;
  logic ode_s;
  logic sclk_d;
  logic rise;
  logic fall;
  logic fs_prev;
  logic [3:0] run_cnt;
  logic idle_level;
  logic idle_known;
  logic pulse_hit;
  logic [CYC_W-1:0] cyc;
  logic [CYC_W-1:0] next_cyc;
  logic [LOST_W-1:0] lost_cnt;
  logic [BITS_PER_CHAN-1:0] rin_sh;
  logic [BITS_PER_CHAN-1:0] sin_sh;
  logic [BITS_PER_CHAN-1:0] rout_mem [CHANNELS];
  logic [BITS_PER_CHAN-1:0] sout_mem [CHANNELS];
  logic [CHAN_W-1:0] next_chan;
  logic [BIT_W-1:0] next_bit;
  logic last_bit_rise;

  // Every pin from the backplane is asynchronous to the master clock.
  tps_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .d_i({output_drive_enable_i, sin_i, rin_i, frame_sync_in_i, serial_bit_clock_i}),
    .q_o(sync_q)
  );

  assign sclk_s = sync_q[0];
  assign fs_s = sync_q[1];
  assign rin_s = sync_q[2];
  assign sin_s = sync_q[3];
  assign ode_s = sync_q[4];

  // Edges of the serial clock are found on the synchronised copy only.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  assign rise = sclk_s & ~sclk_d;
  assign fall = ~sclk_s & sclk_d;

  // The level the frame line holds for a long run is its idle level; the pulse is the other.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      fs_prev <= 1'b1;
      run_cnt <= 4'h0;
      idle_level <= 1'b1;
      idle_known <= 1'b0;
    end else if (fall) begin
      fs_prev <= fs_s;
      if (fs_s != fs_prev) begin
        run_cnt <= 4'h0;
      end else if (run_cnt != IDLE_RUN) begin
        run_cnt <= run_cnt + 4'h1;
      end else begin
        idle_level <= fs_s;
        idle_known <= 1'b1;
      end
    end
  end

  // Only the first active sample of a pulse aligns the frame, so wide pulses do not stall it.
  assign pulse_hit = fall && idle_known && (fs_s != idle_level) && (fs_prev == idle_level);

  // An idle-low line means an active-high pulse, the GCI style.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      gci_mode_o <= 1'b0;
    end else begin
      gci_mode_o <= ~idle_level;
    end
  end

  // Frame cycle counter: two serial clocks per bit, eight bits per slot, wraps after a frame.
  always_comb begin
    next_cyc = pulse_hit ? '0 : cyc + {{(CYC_W-1){1'b0}}, 1'b1};
    next_chan = next_cyc[CYC_W-1 -: CHAN_W];
    next_bit = next_cyc[BIT_W:1];
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cyc <= '0;
    end else if (fall) begin
      cyc <= next_cyc;
    end
  end

  // Lock is lost when no pulse comes within a frame and a little.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      lost_cnt <= '0;
      frame_locked_o <= 1'b0;
    end else if (pulse_hit) begin
      lost_cnt <= '0;
      frame_locked_o <= 1'b1;
    end else if (fall) begin
      if (lost_cnt == LOST_LIMIT) begin
        frame_locked_o <= 1'b0;
      end else begin
        lost_cnt <= lost_cnt + {{(LOST_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Inputs are sampled at the rising edge inside the second clock of each bit, mid-eye.
  assign last_bit_rise = rise && cyc[0] && (cyc[BIT_W:1] == LAST_BIT);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rin_sh <= '0;
      sin_sh <= '0;
    end else if (rise && cyc[0]) begin
      rin_sh <= {rin_sh[BITS_PER_CHAN-2:0], rin_s};
      sin_sh <= {sin_sh[BITS_PER_CHAN-2:0], sin_s};
    end
  end

  // A completed slot goes to the core as one sample pair, a one-cycle strobe.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sample_valid_o <= 1'b0;
      sample_o <= '0;
    end else begin
      sample_valid_o <= last_bit_rise;
      if (last_bit_rise) begin
        sample_o.chan <= cyc[CYC_W-1 -: CHAN_W];
        sample_o.rin <= {rin_sh[BITS_PER_CHAN-2:0], rin_s};
        sample_o.sin <= {sin_sh[BITS_PER_CHAN-2:0], sin_s};
      end
    end
  end

  // Frame stores; received bytes leave in the same slot of the next frame.
  generate
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_slot
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          rout_mem[ch] <= '0;
          sout_mem[ch] <= '0;
        end else begin
          if (last_bit_rise && (cyc[CYC_W-1 -: CHAN_W] == CHAN_W'(ch))) begin
            rout_mem[ch] <= {rin_sh[BITS_PER_CHAN-2:0], rin_s};
          end
          if (cancel_valid_i && (cancel_i.chan == CHAN_W'(ch))) begin
            sout_mem[ch] <= cancel_i.data;
          end
        end
      end
    end
  endgenerate

  // Outputs launch MSB first on the falling edge that opens each bit.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rout_o <= 1'b1;
      sout_o <= 1'b1;
    end else if (fall) begin
      rout_o <= rout_mem[next_chan][LAST_BIT - next_bit];
      sout_o <= sout_mem[next_chan][LAST_BIT - next_bit];
    end
  end

  // The drive bit comes from core logic on this clock, so only the pin is synchronised.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rout_oe_o <= 1'b0;
      sout_oe_o <= 1'b0;
    end else begin
      rout_oe_o <= ode_s & output_drive_enable_bit_i;
      sout_oe_o <= ode_s & output_drive_enable_bit_i;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_slot_end;
    rise && cyc[0] && (cyc[BIT_W:1] == LAST_BIT);
  endsequence

  sequence s_strobe;
    sample_valid_o ##1 !sample_valid_o;
  endsequence

  property p_drive_gate;
    !output_drive_enable_bit_i |=> !rout_oe_o && !sout_oe_o;
  endproperty
  a_drive_gate: assert property (p_drive_gate) else $error("Outputs enabled while drive bit low.");

  property p_drive_pin;
    !$past(ode_s) && !rst_i |-> !rout_oe_o && !sout_oe_o;
  endproperty
  a_drive_pin: assert property (p_drive_pin) else $error("Outputs enabled while drive pin low.");

  property p_align;
    pulse_hit |=> (cyc == '0);
  endproperty
  a_align: assert property (p_align) else $error("Frame pulse did not align the counter.");

  property p_step;
    fall && !pulse_hit |=> (cyc == CYC_W'($past(cyc) + 1));
  endproperty
  a_step: assert property (p_step) else $error("Frame counter did not advance by one.");

  property p_rout_bit;
    fall |=> (rout_o == $past(rout_mem[next_chan][LAST_BIT - next_bit]));
  endproperty
  a_rout_bit: assert property (p_rout_bit) else $error("Receive output bit wrong.");

  property p_sout_bit;
    fall |=> (sout_o == $past(sout_mem[next_chan][LAST_BIT - next_bit]));
  endproperty
  a_sout_bit: assert property (p_sout_bit) else $error("Send output bit wrong.");

  property p_sample_out;
    s_slot_end |=> s_strobe and (sample_o.chan == $past(cyc[CYC_W-1 -: CHAN_W]));
  endproperty
  a_sample_out: assert property (p_sample_out) else $error("Slot sample not delivered.");

  property p_rx_store;
    s_slot_end |=> (rout_mem[$past(cyc[CYC_W-1 -: CHAN_W])] == sample_o.rin);
  endproperty
  a_rx_store: assert property (p_rx_store) else $error("Receive byte not stored.");

  property p_mode;
    ##1 (gci_mode_o == !$past(idle_level));
  endproperty
  a_mode: assert property (p_mode) else $error("Pulse format flag wrong.");

  property p_edges;
    !(rise && fall) and (rise |-> sclk_s);
  endproperty
  a_edges: assert property (p_edges) else $error("Serial clock edge detect wrong.");
endmodule
`default_nettype wire

// >>> tps_sync.sv
// Two-flip-flop synchroniser for a bundle of asynchronous inputs.
`timescale 1ns/1ps
`default_nettype none
module tps_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second stage, never any logic.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
`default_nettype wire

// >>> tps_tdm_model.sv
// Behavioural TDM backplane framer: clock, frame pulse and both input streams.
`timescale 1ns/1ps
`default_nettype none
module tps_tdm_model (
  input wire logic run_i,
  input wire logic gci_i,
  output logic sclk_o,
  output wire logic fs_o,
  output logic rin_o,
  output logic sin_o,
  output logic [8:0] k_o,
  output logic [7:0] frame_o
);
  logic act;
  logic [7:0] d;
  logic [8:0] nk;
  // The byte moves every frame, so a wrong frame latency shows up.
  function automatic logic [7:0] pat(input logic [7:0] f, input logic [4:0] n);
    return {3'h0, n} * 8'h07 + f;
  endfunction
  // Start state: clock low, idle line, parked before the first frame.
  initial begin
    sclk_o = 1'b0;
    act = 1'b0;
    rin_o = 1'b0;
    sin_o = 1'b0;
    k_o = 9'h1F0;
    frame_o = 8'hFF;
  end
  // The clock stands still while no frames run.
  always #40 sclk_o = run_i ? ~sclk_o : 1'b0;
  // The pulse covers one clock around the fall that opens slot 0.
  always @(posedge sclk_o or negedge run_i) act <= run_i && k_o == 9'h1FF;
  assign fs_o = act ^ ~gci_i;
  // Data changes on falls, so it is steady at the rising edge that samples it.
  always @(negedge sclk_o or negedge run_i) begin
    if (!run_i) begin
      k_o <= 9'h1F0;
      frame_o <= 8'hFF;
    end else begin
      nk = k_o + 9'h001;
      d = pat(frame_o + {7'h00, nk == 9'h000}, nk[8:4]);
      k_o <= nk;
      frame_o <= frame_o + {7'h00, nk == 9'h000};
      rin_o <= d[3'h7 - nk[3:1]];
      sin_o <= ~d[3'h7 - nk[3:1]];
    end
  end
endmodule
`default_nettype wire
